// ### rtl/dma_xfer_pkg.sv
// Constants, types and rule summary shared by both ends of the host DMA transfer link.
//
// Contract
// - Software sees flag showing DMA FIFO holds data; status bit 7 here is set when the FIFO is empty instead.
// - Send residual is pointer minus count, masked.
// - Receive residual is masked difference, two's complemented.
// - Bit 5 shows output latch lane full.
// - Bit 6 shows output register lane full.
// - Bit 7 shows input latch lane full.
// - Control two bit 0 shows wide residue.
// - Bits 7-4 count synchronous receive FIFO bytes.
// - Seven bus modes chosen by mode pins.
// - Transfers may start or end misaligned.
// - Never issue a three-byte bus transfer.
// - Throttling forbids size change within one ownership.
// - Dma control bit 7 enables size throttling.
// - Software keeps snoop mode clear when throttling.
// - Chip test zero bit 7 disables bursting; here control bit 15 disables it instead.
// - Burst, no throttle: align stepwise, then one ownership.
// - Burst plus throttle: burst and longwords share ownership.
// - Neither: group up to burst length per ownership.
// - Throttle only: longwords together, tail separate ownerships.
// - Neither error nor ack waits; ack alone completes.
// - Error alone faults; error with ack retries.
// - Mode 1 retries on bus error plus halt.
// - Unqualified bus error sets status bit 5, stops.
// - Retry re-requests at once with same address, size.
`default_nettype none

package dma_xfer_pkg;

  // ==========================================================================
  // Register offsets (AXI4-Lite byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_FIFO = 8'h10;
  localparam logic [7:0] OFF_SCSI = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_THROTTLE_BIT = 7;
  localparam int CTRL_CACHE_BURST_DISABLE_BIT = 15;
  localparam int CTRL_SNOOP_BIT = 16;
  localparam int STAT_FIFO_EMPTY_BIT = 7;
  localparam int STAT_BUS_FAULT_BIT = 5;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int SST_IN_LATCH_BIT = 7;
  localparam int SST_OUT_REG_BIT = 6;
  localparam int SST_OUT_LATCH_BIT = 5;
  localparam int SCSI_CONTROL_TWO_WIDE_BIT = 0;

  // ==========================================================================
  // Reset values, counts and masks
  // ==========================================================================
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [6:0] RESIDUAL_MASK = 7'h7F;
  localparam int BURST_LEN_DEFAULT = 8;
  localparam int CACHE_LINE_BYTES = 16;
  localparam int MODE_COUNT = 7;

  // Transfer sizes as driven on the bus; a three-byte code does not exist.
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_LINE} size_t;

  // Bus modes 1..7 on three mode select pins.
  typedef logic [2:0] bus_mode_t;
  localparam bus_mode_t MODE_ONE = 3'h1;
  localparam bus_mode_t MODE_TWO = 3'h2;

endpackage

`default_nettype wire

// ### rtl/dma_host_bus_if.sv
// Host processor bus between the DMA master and the bus slave with its arbiter.
`default_nettype none

interface dma_host_bus_if;
  import dma_xfer_pkg::*;
  logic bus_req;
  logic bus_grant;
  logic cyc_valid;
  logic cyc_write;
  logic [31:0] cyc_addr;
  size_t cyc_size;
  logic [31:0] cyc_wdata;
  logic [31:0] cyc_rdata;
  logic transfer_ack_in;
  logic transfer_error_in;
  logic bus_error_in;
  logic halt_in;
  bus_mode_t bus_mode;

  modport master (
    output bus_req, cyc_valid, cyc_write, cyc_addr, cyc_size, cyc_wdata,
    input bus_grant, cyc_rdata, transfer_ack_in, transfer_error_in, bus_error_in, halt_in, bus_mode
  );
  modport slave (
    input bus_req, cyc_valid, cyc_write, cyc_addr, cyc_size, cyc_wdata,
    output bus_grant, cyc_rdata, transfer_ack_in, transfer_error_in, bus_error_in, halt_in, bus_mode
  );
endinterface

`default_nettype wire

// ### rtl/dma_bus_slave.sv
// Host bus slave and arbiter end: grants the bus and terminates master cycles.
`default_nettype none

module dma_bus_slave (
  input wire logic clock_in,
  input wire logic rst_in,
  dma_host_bus_if.slave bus,
  input wire logic [2:0] mode_select_in,
  input wire logic wait_in,
  input wire logic error_in,
  input wire logic retry_in,
  input wire logic [31:0] read_data_in,
  output logic cycle_seen_out,
  output logic [31:0] last_addr_out,
  output logic [31:0] last_wdata_out,
  output logic [1:0] last_size_out
);
  import dma_xfer_pkg::*;

  logic grant_q;
  logic ack_q;
  logic tea_q;
  logic bus_error_in_q;
  logic halt_q;
  logic seen_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0] size_q;
  logic [2:0] mode_q;
  logic respond;

  // A termination is driven for one cycle; the master sees it and drops valid.
  assign respond = bus.cyc_valid && grant_q && !ack_q && !tea_q && !bus_error_in_q && !wait_in;

  // ==========================================================================
  // Arbitration
  // ==========================================================================
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      grant_q <= 1'b0;
    else
      grant_q <= bus.bus_req;
  end

  // ==========================================================================
  // Cycle termination
  // ==========================================================================
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ack_q <= 1'b0;
      tea_q <= 1'b0;
      bus_error_in_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else if (respond)
    begin
      // Retry coding differs by mode: mode 1 uses bus error with halt.
      if (mode_q == MODE_ONE)
      begin
        ack_q <= !error_in && !retry_in;
        tea_q <= 1'b0;
        bus_error_in_q <= error_in || retry_in;
        halt_q <= retry_in;
      end
      else
      begin
        ack_q <= retry_in || !error_in;
        tea_q <= error_in || retry_in;
        bus_error_in_q <= 1'b0;
        halt_q <= 1'b0;
      end
    end
    else
    begin
      ack_q <= 1'b0;
      tea_q <= 1'b0;
      bus_error_in_q <= 1'b0;
      halt_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      seen_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      size_q <= 2'h0;
      mode_q <= 3'h1;
    end
    else
    begin
      mode_q <= mode_select_in;
      seen_q <= respond;
      rdata_q <= read_data_in;
      if (respond)
      begin
        addr_q <= bus.cyc_addr;
        wdata_q <= bus.cyc_wdata;
        size_q <= bus.cyc_size;
      end
    end
  end

  assign bus.bus_grant = grant_q;
  assign bus.transfer_ack_in = ack_q;
  assign bus.transfer_error_in = tea_q;
  assign bus.bus_error_in = bus_error_in_q;
  assign bus.halt_in = halt_q;
  assign bus.cyc_rdata = rdata_q;
  assign bus.bus_mode = mode_q;
  assign cycle_seen_out = seen_q;
  assign last_addr_out = addr_q;
  assign last_wdata_out = wdata_q;
  assign last_size_out = size_q;

endmodule

`default_nettype wire

// ### rtl/dma_master.sv
// DMA master end: AXI4-Lite registers, ownership sequencing and cycle termination decode.
`default_nettype none

module dma_master #(
  parameter int BURST_LEN = dma_xfer_pkg::BURST_LEN_DEFAULT
) (
  input wire logic clock_in,
  input wire logic rst_in,
  dma_host_bus_if.master bus,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] dma_fifo_pointer_in,
  input wire logic [7:0] scsi_status_low_lane_in,
  input wire logic [7:0] scsi_status_high_lane_in,
  input wire logic [7:0] scsi_control_two_in,
  output logic done_out
);
  import dma_xfer_pkg::*;

  // The beat counter is eight bits wide, so longer bursts cannot be counted.
  if (BURST_LEN < 1 || BURST_LEN > 255)
  begin
    $error("BURST_LEN out of range");
  end

  typedef enum {ST_IDLE, ST_REQ, ST_CYCLE, ST_RELEASE} state_t;

  state_t state_q;
  logic [31:0] ctrl_q;
  logic [31:0] addr_q;
  logic [23:0] dma_byte_counter_q;
  logic fault_q;
  logic done_q;
  logic [7:0] beats_q;
  logic aligned_q;
  size_t own_size_q;
  size_t cur_size;
  logic [4:0] cur_bytes;
  logic new_own;
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic req_q;
  logic cyc_q;
  logic is_retry;
  logic is_fault;
  logic is_ack;
  logic [6:0] residual;

  // Size chosen for the next cycle; a byte count of three is never emitted.
  function automatic size_t pick_size(input logic [31:0] a, input logic [23:0] n, input logic cache_burst_disable);
    if (a[0] || n < 24'd2)
      return SIZE_BYTE;
    else if (a[1] || n < 24'd4)
      return SIZE_WORD;
    else if (!cache_burst_disable && a[3:0] == 4'h0 && n >= 24'(CACHE_LINE_BYTES))
      return SIZE_LINE;
    else
      return SIZE_LONG;
  endfunction

  function automatic logic [4:0] size_bytes(input size_t s);
    unique case (s)
      SIZE_BYTE: return 5'd1;
      SIZE_WORD: return 5'd2;
      SIZE_LONG: return 5'd4;
      SIZE_LINE: return 5'd16;
    endcase
  endfunction

  assign cur_size = pick_size(addr_q, dma_byte_counter_q, ctrl_q[CTRL_CACHE_BURST_DISABLE_BIT]);
  assign cur_bytes = size_bytes(cur_size);

  // Decide whether the next cycle must start a fresh bus ownership.
  always_comb
  begin
    new_own = 1'b0;
    if (ctrl_q[CTRL_THROTTLE_BIT])
      // Line and longword count as one size; any other change splits.
      new_own = (!((own_size_q == SIZE_LINE || own_size_q == SIZE_LONG)
                  && (cur_size == SIZE_LINE || cur_size == SIZE_LONG)) && own_size_q != cur_size)
                || (!ctrl_q[CTRL_CACHE_BURST_DISABLE_BIT] && !aligned_q);
    else if (!ctrl_q[CTRL_CACHE_BURST_DISABLE_BIT])
      // Until a cycle starts on a line boundary every cycle is its own ownership.
      new_own = !aligned_q;
    else
      new_own = beats_q >= 8'(BURST_LEN);
  end

  // Termination decode; mode 1 retries on bus error with halt.
  assign is_retry = (bus.bus_mode == MODE_ONE) ? (bus.bus_error_in && bus.halt_in)
                    : (bus.transfer_error_in && bus.transfer_ack_in);
  assign is_fault = (bus.bus_mode == MODE_ONE) ? (bus.bus_error_in && !bus.halt_in)
                    : (bus.transfer_error_in && !bus.transfer_ack_in);
  assign is_ack = bus.transfer_ack_in && !bus.transfer_error_in && !bus.bus_error_in;

  // ==========================================================================
  // Ownership and cycle sequencing
  // ==========================================================================
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      req_q <= 1'b0;
      cyc_q <= 1'b0;
      beats_q <= 8'h00;
      own_size_q <= SIZE_BYTE;
      aligned_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          aligned_q <= 1'b0;
          if (ctrl_q[CTRL_START_BIT] && dma_byte_counter_q != 24'h0 && !fault_q)
          begin
            state_q <= ST_REQ;
            req_q <= 1'b1;
          end
        end
        ST_REQ:
        begin
          // A dropped request is raised again first, so a stale grant never opens a cycle.
          if (!req_q)
            req_q <= 1'b1;
          else if (bus.bus_grant)
          begin
            state_q <= ST_CYCLE;
            cyc_q <= 1'b1;
            own_size_q <= cur_size;
            beats_q <= 8'h01;
            aligned_q <= aligned_q || addr_q[3:0] == 4'h0;
          end
        end
        ST_CYCLE:
        begin
          if (is_retry || is_fault)
          begin
            // Drop the bus; a retry asks again at once with address and size kept.
            cyc_q <= 1'b0;
            req_q <= 1'b0;
            state_q <= is_retry ? ST_REQ : ST_IDLE;
          end
          else if (is_ack)
          begin
            cyc_q <= 1'b0;
            state_q <= ST_RELEASE;
          end
        end
        ST_RELEASE:
        begin
          // The bus stays owned while the next cycle may join this ownership.
          if (dma_byte_counter_q == 24'h0 || new_own)
          begin
            req_q <= 1'b0;
            state_q <= (dma_byte_counter_q == 24'h0) ? ST_IDLE : ST_REQ;
          end
          else
          begin
            state_q <= ST_CYCLE;
            cyc_q <= 1'b1;
            beats_q <= beats_q + 8'h01;
            own_size_q <= cur_size;
            aligned_q <= aligned_q || addr_q[3:0] == 4'h0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Address, count and status
  // ==========================================================================
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      addr_q <= 32'h0000_0000;
      dma_byte_counter_q <= 24'h00_0000;
      fault_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_CYCLE && is_ack)
      begin
        addr_q <= addr_q + 32'(cur_bytes);
        dma_byte_counter_q <= dma_byte_counter_q - 24'(cur_bytes);
        done_q <= dma_byte_counter_q == 24'(cur_bytes);
      end
      if (state_q == ST_CYCLE && is_fault)
        fault_q <= 1'b1;
      if (aw_hold_q && w_hold_q && !bvalid_q && aw_addr_q[7:0] == OFF_ADDR)
        addr_q <= w_data_q;
      if (aw_hold_q && w_hold_q && !bvalid_q && aw_addr_q[7:0] == OFF_COUNT)
        dma_byte_counter_q <= w_data_q[23:0];
      // Reading status clears the sticky flags unless a new event lands the same cycle.
      if (s_axi_arvalid && !rvalid_q && s_axi_araddr[7:0] == OFF_STATUS)
      begin
        if (!(state_q == ST_CYCLE && is_fault))
          fault_q <= 1'b0;
        if (!(state_q == ST_CYCLE && is_ack && dma_byte_counter_q == 24'(cur_bytes)))
          done_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite register slave
  // ==========================================================================
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_q)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q)
      begin
        bvalid_q <= 1'b1;
        if (aw_addr_q[7:0] == OFF_CTRL && s_axi_wstrb != 4'h0)
          ctrl_q <= w_data_q;
      end
      else if (state_q != ST_IDLE && ctrl_q[CTRL_START_BIT])
        ctrl_q[CTRL_START_BIT] <= 1'b0;
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  // Residual count: send uses the masked difference, receive its two's complement.
  assign residual = ctrl_q[CTRL_DIR_BIT]
                    ? 7'((~((dma_fifo_pointer_in - dma_byte_counter_q[6:0]) & RESIDUAL_MASK)) + 7'h01)
                    : ((dma_fifo_pointer_in - dma_byte_counter_q[6:0]) & RESIDUAL_MASK);

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      unique case (s_axi_araddr[7:0])
        OFF_CTRL: rdata_q <= ctrl_q;
        OFF_ADDR: rdata_q <= addr_q;
        OFF_COUNT: rdata_q <= {8'h00, dma_byte_counter_q};
        // FIFO empty flag, fault, done and busy.
        OFF_STATUS: rdata_q <= {24'h00_0000, residual == 7'h00, 1'b0, fault_q, 2'h0, done_q, 1'b0,
                                state_q != ST_IDLE};
        OFF_FIFO: rdata_q <= {25'h000_0000, residual};
        // Lane status bits 7..4 and the wide residue bit pass through.
        OFF_SCSI: rdata_q <= {8'h00, scsi_control_two_in, scsi_status_high_lane_in, scsi_status_low_lane_in};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = 2'h0;
  assign bus.bus_req = req_q;
  assign bus.cyc_valid = cyc_q;
  assign bus.cyc_write = ctrl_q[CTRL_DIR_BIT];
  assign bus.cyc_addr = addr_q;
  assign bus.cyc_size = own_size_q;
  assign bus.cyc_wdata = 32'h0000_0000;
  assign done_out = done_q;

endmodule

`default_nettype wire

// ### testbench/dma_link_properties.sv
// Concurrent checks on the host bus between the DMA master and the bus slave.
`default_nettype none

module dma_link_checker
  import dma_xfer_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic bus_req,
  input wire logic bus_grant,
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire size_t cyc_size,
  input wire logic transfer_ack_in,
  input wire logic transfer_error_in,
  input wire logic bus_error_in,
  input wire logic halt_in,
  input wire bus_mode_t bus_mode
);
  // =====
  // Termination decode and checks
  // =====
  // Mode one qualifies a retry with halt, so a bare error there is a fault.
  logic retry_c;
  logic fault_c;
  logic [31:0] retry_addr_q;
  size_t retry_size_q;
  assign retry_c = cyc_valid && (bus_mode == MODE_ONE ? bus_error_in && halt_in : transfer_error_in && transfer_ack_in);
  assign fault_c = cyc_valid && (bus_mode == MODE_ONE ? bus_error_in && !halt_in : transfer_error_in && !transfer_ack_in);
  always_ff @(posedge clock_in)
  begin
    if (retry_c)
    begin
      retry_addr_q <= cyc_addr;
      retry_size_q <= cyc_size;
    end
  end
  default clocking link_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  grant_after_req_a: assert property ($rose(bus_req) |=> bus_grant)
    else $error("grant missing after request");
  valid_owned_a: assert property (cyc_valid |-> bus_grant)
    else $error("cycle open without grant");
  wait_holds_a: assert property (cyc_valid && !transfer_ack_in && !transfer_error_in && !bus_error_in
    |=> cyc_valid && $stable(cyc_addr) && $stable(cyc_size)) else $error("cycle changed during wait");
  ack_ends_a: assert property (cyc_valid && transfer_ack_in && !transfer_error_in && !bus_error_in
    |=> !cyc_valid || $changed(cyc_addr)) else $error("acknowledged cycle repeated");
  fault_stops_a: assert property (fault_c |-> ##[1:2] (!bus_req && !cyc_valid) [*8])
    else $error("bus requested after fault");
  retry_release_a: assert property (retry_c |=> !cyc_valid)
    else $error("bus kept after retry");
  retry_again_a: assert property (retry_c |-> ##[1:3] bus_req ##[1:12]
    (cyc_valid && cyc_addr == retry_addr_q && cyc_size == retry_size_q)) else $error("retry not repeated");
  size_aligned_a: assert property (cyc_valid |-> (cyc_size != SIZE_LINE || cyc_addr[3:0] == 4'h0)
    && (cyc_size != SIZE_LONG || cyc_addr[1:0] == 2'h0) && (cyc_size != SIZE_WORD || !cyc_addr[0]))
    else $error("size does not fit address");
endmodule

`default_nettype wire

// ### testbench/tb_top.sv
// Testbench joining the DMA master to the bus slave.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_xfer_pkg::*;
  // =====
  // Signals, ends and monitor
  // =====
  logic clock_in = 1'b0, rst_in = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, hold = 1'b0, err = 1'b0, retry = 1'b0, grant_d = 1'b0, fresh = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, last_addr;
  logic [6:0] fifo_ptr = 7'h00;
  logic [7:0] low_lane = 8'h00, high_lane = 8'h00, ctl_two = 8'h00;
  bus_mode_t mode_sel = MODE_TWO;
  size_t own_cls = SIZE_BYTE;
  int fails = 0, n_tests = 0, cycles = 0, owners = 0, bytes_moved = 0, size_mix = 0;
  dma_host_bus_if link();
  dma_master #(.BURST_LEN(8)) dma_master_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dma_fifo_pointer_in(fifo_ptr), .scsi_status_low_lane_in(low_lane), .scsi_status_high_lane_in(high_lane),
    .scsi_control_two_in(ctl_two), .done_out(done));
  dma_bus_slave dma_bus_slave_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(link), .mode_select_in(mode_sel),
    .wait_in(hold), .error_in(err), .retry_in(retry), .read_data_in(32'h5A5A_C3C3), .cycle_seen_out(),
    .last_addr_out(last_addr), .last_wdata_out(), .last_size_out());
  dma_link_checker dma_link_checker_inst (.clock_in(clock_in), .rst_in(rst_in), .bus_req(link.bus_req),
    .bus_grant(link.bus_grant), .cyc_valid(link.cyc_valid), .cyc_addr(link.cyc_addr), .cyc_size(link.cyc_size),
    .transfer_ack_in(link.transfer_ack_in), .transfer_error_in(link.transfer_error_in),
    .bus_error_in(link.bus_error_in), .halt_in(link.halt_in), .bus_mode(link.bus_mode));
  always #20 clock_in = ~clock_in;
  // Line and longword count as one size, so throttling may mix them.
  function automatic size_t cls(size_t s);
    return s == SIZE_LINE ? SIZE_LONG : s;
  endfunction
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    grant_d <= link.bus_grant;
    if (link.bus_grant && !grant_d)
    begin
      owners <= owners + 1;
      fresh <= 1'b1;
    end
    if (link.cyc_valid && link.transfer_ack_in && !link.transfer_error_in && !link.bus_error_in)
    begin
      bytes_moved <= bytes_moved + (link.cyc_size == SIZE_LINE ? CACHE_LINE_BYTES : 1 << link.cyc_size);
      if (!fresh && cls(link.cyc_size) != own_cls)
        size_mix <= size_mix + 1;
      own_cls <= cls(link.cyc_size);
      fresh <= 1'b0;
    end
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit pa = 1'b1, pw = 1'b1, pb = 1'b1;
    @(posedge clock_in);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw || pb)
    begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (pb && bvalid) bready <= 1'b0;
      pa = pa && !awready;
      pw = pw && !wready;
      pb = pb && !bvalid;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    bit pa = 1'b1;
    @(posedge clock_in);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock_in);
      if (pa && arready) arvalid <= 1'b0;
      pa = pa && !arready;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rready <= 1'b0;
  endtask
  task automatic start_xfer(input logic [31:0] a, input logic [31:0] n, input logic [31:0] ctl);
    axi_wr(OFF_ADDR, a);
    axi_wr(OFF_COUNT, n);
    axi_wr(OFF_CTRL, ctl | 32'h1);
  endtask
  task automatic finish_xfer();
    while (done !== 1'b1)
      @(posedge clock_in);
    axi_rd(OFF_STATUS);
    check(32'(rd[STAT_DONE_BIT]), 32'h1);
  endtask
  task automatic t_status();
    fifo_ptr <= 7'h25;
    low_lane <= 8'hA0;
    high_lane <= 8'h70;
    ctl_two <= 8'h01;
    axi_wr(OFF_COUNT, 32'h0000_0010);
    axi_wr(OFF_CTRL, 32'h0000_0000);
    axi_rd(OFF_FIFO);
    check(rd, 32'h0000_0015);
    axi_rd(OFF_STATUS);
    check(32'(rd[STAT_FIFO_EMPTY_BIT]), 32'h0);
    axi_wr(OFF_CTRL, 32'h0000_0002);
    axi_rd(OFF_FIFO);
    check(rd, 32'h0000_006B);
    axi_rd(OFF_SCSI);
    check(rd, 32'h0001_70A0);
    fifo_ptr <= 7'h10;
    axi_rd(OFF_STATUS);
    check(32'(rd[STAT_FIFO_EMPTY_BIT]), 32'h1);
    $display("status test ends");
  endtask
  task automatic t_xfer(input logic [31:0] ctl, input int exp_own);
    owners = 0;
    bytes_moved = 0;
    size_mix = 0;
    start_xfer(32'h0000_1001, 32'd38, ctl);
    finish_xfer();
    check(owners, exp_own);
    check(bytes_moved, 38);
    if (ctl[CTRL_THROTTLE_BIT])
      check(size_mix, 0);
    $display("transfer test %h ends", ctl);
  endtask
  task automatic t_wait();
    hold <= 1'b1;
    start_xfer(32'h0000_2000, 32'd4, 32'h0);
    repeat (20)
      @(posedge clock_in);
    check(32'(done), 32'h0);
    check(32'(link.cyc_valid), 32'h1);
    hold <= 1'b0;
    finish_xfer();
    $display("wait test ends");
  endtask
  task automatic t_fault(input bus_mode_t m);
    mode_sel <= m;
    err <= 1'b1;
    start_xfer(32'h0000_3000, 32'd8, 32'h0);
    repeat (30)
      @(posedge clock_in);
    check(32'(done), 32'h0);
    check(32'(link.bus_req), 32'h0);
    axi_rd(OFF_STATUS);
    check(32'(rd[STAT_BUS_FAULT_BIT]), 32'h1);
    err <= 1'b0;
    @(posedge clock_in);
    $display("fault test ends");
  endtask
  task automatic t_retry(input bus_mode_t m);
    mode_sel <= m;
    retry <= 1'b1;
    bytes_moved = 0;
    start_xfer(32'h0000_4000, 32'd8, 32'h0);
    repeat (12)
      @(posedge clock_in);
    retry <= 1'b0;
    finish_xfer();
    check(32'(rd[STAT_BUS_FAULT_BIT]), 32'h0);
    check(bytes_moved, 8);
    check(last_addr, 32'h0000_4004);
    $display("retry test ends");
  endtask
  // Snoop mode, bit 16, stays clear in every control word.
  initial
  begin
    repeat (16)
      @(posedge clock_in);
    rst_in <= 1'b0;
    t_status();
    t_xfer(32'h0000_0000, 6);
    t_xfer(32'h0000_0080, 8);
    t_xfer(32'h0000_8000, 2);
    t_xfer(32'h0000_8080, 5);
    t_wait();
    t_fault(MODE_ONE);
    t_fault(MODE_TWO);
    t_retry(MODE_ONE);
    t_retry(MODE_TWO);
    give_verdict();
  end
endmodule

`default_nettype wire
